// [design/csl_led_sequencer.sv]
// Front-panel LED sequencer for an eight-channel field module.
// ----------------------------------------------------------------
// Behaviour
// - Power and fault LEDs on first.
// - Red LEDs light ascending, staying lit.
// - Then red LEDs go off ascending.
// - Same light/off sequence on amber LEDs.
// - Red LEDs show address switches after test.
// - Hold address two seconds, then fault off.
// - Unconfigured: all amber blink in unison.
// - Green device LED on while running.
// - Amber device steady when disabled or watchdog.
// - Amber device blinks once, else off unless fault.
// - Relay: red follows energized output.
// - Amber blinks on low power or unconfigured.
// - Analog: red blinks low, steady high alarm.
// - Analog: amber steady when out of range.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module csl_led_sequencer
  import csl_pkg::*;
#(
  parameter int unsigned STEP_CYCLES  = STEP_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC,
  parameter int unsigned ADDR_CYCLES  = ADDR_SHOW_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [NUM_CH-1:0] addrSwitch,
  input  wire logic [NUM_CH-1:0] chOutActive,
  input  wire logic [NUM_CH-1:0] chLowAlarm,
  input  wire logic [NUM_CH-1:0] chHighAlarm,
  input  wire logic [NUM_CH-1:0] chOutOfRange,
  input  wire logic [NUM_CH-1:0] chConfigured,
  input  wire logic              lowPower,
  input  wire logic              wdogFail,
  input  wire logic              devFault,
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdata,
  output logic                   irq,
  output logic                   ledPower,
  output logic                   ledDevFault,
  output logic      [NUM_CH-1:0] ledChRed,
  output logic      [NUM_CH-1:0] ledChAmber
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] ctrl;
  logic [2:0] intStat;
  logic [2:0] intMask;
  csl_state_t state;
  csl_state_t next_state;
  logic [2:0] stepIdx;
  logic       pulseDone;
  logic       pulseActive;

  csl_tick_if tk ();

  csl_ticks #(
    .STEP_CYCLES  (STEP_CYCLES),
    .BLINK_CYCLES (BLINK_CYCLES),
    .ADDR_CYCLES  (ADDR_CYCLES)
  ) u_ticks (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tk    (tk)
  );

  wire isAnalog    = ctrl[CTRL_VARIANT];
  wire modConfig   = ctrl[CTRL_CONFIGURED];
  wire modDisabled = ctrl[CTRL_DISABLED];
  wire blink       = tk.blinkPhase;

  wire wrCtrl    = regWr && (regAddr == REG_CTRL);
  wire wrIntStat = regWr && (regAddr == REG_INTSTAT);
  wire wrIntMask = regWr && (regAddr == REG_INTMASK);
  wire lastStep  = tk.stepTick && (stepIdx == 3'h7);
  wire seqDone   = tk.addrDone && (state == CSL_ST_ADDR);
  wire [2:0] events = {devFault, wdogFail, seqDone};

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= CTRL_RESET;
      intMask <= INTMASK_RESET;
      intStat <= 3'h0;
    end else begin
      if (wrCtrl) ctrl <= regWdata[2:0];
      if (wrIntMask) intMask <= regWdata[2:0];
      // A new event wins over a write-one clear in the same cycle.
      intStat <= (intStat & ~(wrIntStat ? regWdata[2:0] : 3'h0)) | events;
    end
  end

  logic [31:0] next_rdata;
  always_comb begin
    case (regAddr)
      REG_CTRL:    next_rdata = {29'h0, ctrl};
      REG_STATUS:  next_rdata = {26'h0, pulseDone, state == CSL_ST_RUN, 1'b0, stepIdx};
      REG_INTSTAT: next_rdata = {29'h0, intStat};
      REG_INTMASK: next_rdata = {29'h0, intMask};
      default:     next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) regRdata <= 32'h0;
    else regRdata <= regRd ? next_rdata : 32'h0;
  end

  assign irq = |(intStat & intMask);

  // ----------------------------------------------------------------
  // Power-up sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      CSL_ST_START:   if (tk.stepTick) next_state = CSL_ST_RED_ON;
      CSL_ST_RED_ON:  if (lastStep) next_state = CSL_ST_RED_OFF;
      CSL_ST_RED_OFF: if (lastStep) next_state = CSL_ST_AMB_ON;
      CSL_ST_AMB_ON:  if (lastStep) next_state = CSL_ST_AMB_OFF;
      CSL_ST_AMB_OFF: if (lastStep) next_state = CSL_ST_ADDR;
      CSL_ST_ADDR:    if (tk.addrDone) next_state = CSL_ST_RUN;
      CSL_ST_RUN:     next_state = CSL_ST_RUN;
      default:        next_state = CSL_ST_START;
    endcase
  end

  assign tk.addrStart = (state == CSL_ST_AMB_OFF) && lastStep;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= CSL_ST_START;
      stepIdx <= 3'h0;
    end else begin
      state <= next_state;
      if (next_state != state) stepIdx <= 3'h0;
      else if (tk.stepTick) stepIdx <= stepIdx + 3'h1;
    end
  end

  // Single amber device blink after power-up: lit for one blink phase (half a blink cycle).
  logic [1:0] pulseEdges;
  logic       blinkD;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pulseDone   <= 1'b0;
      pulseActive <= 1'b0;
      pulseEdges  <= 2'h0;
      blinkD      <= 1'b0;
    end else begin
      blinkD <= blink;
      if (state == CSL_ST_RUN && !pulseDone && blink != blinkD) begin
        pulseActive <= (pulseEdges == 2'h0);
        pulseEdges  <= pulseEdges + 2'h1;
        if (pulseEdges == 2'h1) pulseDone <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // LED drive
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] fillMask;
  logic [NUM_CH-1:0] clearMask;
  assign fillMask  = NUM_CH'((16'h2 << stepIdx) - 16'h1);
  assign clearMask = ~fillMask;

  logic [NUM_CH-1:0] runRed;
  logic [NUM_CH-1:0] runAmber;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (isAnalog) begin
        runRed[i]   = chHighAlarm[i] || (chLowAlarm[i] && blink);
        runAmber[i] = chOutOfRange[i];
      end else begin
        runRed[i]   = chOutActive[i];
        runAmber[i] = 1'b0;
      end
      if (lowPower || !chConfigured[i] || !modConfig)
        runAmber[i] = blink;
    end
  end

  logic [NUM_CH-1:0] next_red;
  logic [NUM_CH-1:0] next_amber;
  logic              next_fault;
  always_comb begin
    next_red   = '0;
    next_amber = '0;
    next_fault = 1'b1;
    case (state)
      CSL_ST_START:   ;
      CSL_ST_RED_ON:  next_red = fillMask;
      CSL_ST_RED_OFF: next_red = clearMask;
      CSL_ST_AMB_ON:  next_amber = fillMask;
      CSL_ST_AMB_OFF: next_amber = clearMask;
      CSL_ST_ADDR:    next_red = addrSwitch;
      CSL_ST_RUN: begin
        next_red   = runRed;
        next_amber = runAmber;
        next_fault = modDisabled || wdogFail || devFault || pulseActive;
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ledPower    <= 1'b0;
      ledDevFault <= 1'b0;
      ledChRed    <= '0;
      ledChAmber  <= '0;
    end else begin
      ledPower    <= 1'b1;
      ledDevFault <= next_fault;
      ledChRed    <= next_red;
      ledChAmber  <= next_amber;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Counts the cycles spent showing the address, for the hold-time check.
  logic [31:0] addrLen;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) addrLen <= 32'h0;
    else if (state == CSL_ST_ADDR) addrLen <= addrLen + 32'h1;
    else addrLen <= 32'h0;
  end

  startLeds_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && $past(state) == CSL_ST_START |-> ledPower && ledDevFault && ledChRed == '0)
    else $error("power-up lamps wrong");
  redFill_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RED_ON && $past(state) == CSL_ST_RED_ON |-> ledChRed[0])
    else $error("red fill missing channel 1");
  redClear_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RED_OFF && $past(state) == CSL_ST_RED_OFF
      |-> !ledChRed[0] && (ledChRed[7] || ledChRed == '0))
    else $error("red clear order wrong");
  amberTest_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_AMB_ON |-> ledChRed == '0 && ledChAmber[0])
    else $error("amber test wrong");
  addrShow_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_ADDR |-> ledChRed == $past(addrSwitch))
    else $error("address display mismatch");
  addrEnd_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_ADDR && next_state == CSL_ST_RUN
      |-> ##2 ledDevFault == $past(modDisabled || wdogFail || devFault))
    else $error("fault LED not released");
  unconfBlink_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && !modConfig |=> ledChAmber == {NUM_CH{$past(blink)}})
    else $error("amber LEDs not in unison");
  greenOn_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> ledPower)
    else $error("power LED off");
  wdogAmber_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && wdogFail |=> ledDevFault)
    else $error("watchdog not shown");
  relayRed_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && !isAnalog |=> ledChRed == $past(chOutActive))
    else $error("relay red mismatch");
  highAlarm_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && isAnalog
      |=> ledChRed == $past(chHighAlarm | (chLowAlarm & {NUM_CH{blink}})))
    else $error("alarm red mismatch");
  outRange_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && isAnalog && !lowPower && modConfig && chConfigured[0]
      && chOutOfRange[0] |=> ledChAmber[0])
    else $error("out of range not shown");
  lowPwr_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && lowPower |=> ledChAmber[1] == $past(blink))
    else $error("low power blink wrong");

  redGrow_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_RED_ON && $past(state, 2) == CSL_ST_RED_ON
      |-> (ledChRed & $past(ledChRed)) == $past(ledChRed))
    else $error("red fill dropped a lamp");
  redShrink_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_RED_OFF && $past(state, 2) == CSL_ST_RED_OFF
      |-> (ledChRed & ~$past(ledChRed)) == '0)
    else $error("red clear relit a lamp");
  amberGrow_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_AMB_ON && $past(state, 2) == CSL_ST_AMB_ON
      |-> (ledChAmber & $past(ledChAmber)) == $past(ledChAmber))
    else $error("amber fill dropped a lamp");
  amberShrink_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_AMB_OFF && $past(state, 2) == CSL_ST_AMB_OFF
      |-> (ledChAmber & ~$past(ledChAmber)) == '0)
    else $error("amber clear relit a lamp");
  amberIdle_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_RED_ON || $past(state) == CSL_ST_RED_OFF |-> ledChAmber == '0)
    else $error("amber lit during red test");
  addrAmber_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(state) == CSL_ST_ADDR |-> ledChAmber == '0)
    else $error("amber lit during address display");
  addrHold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_ADDR && next_state == CSL_ST_RUN |-> addrLen == ADDR_CYCLES - 1)
    else $error("address display length wrong");
  seqFault_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && state != CSL_ST_RUN |=> ledDevFault)
    else $error("fault LED dropped during power-up");
  disabledAmber_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && modDisabled |=> ledDevFault)
    else $error("disable not shown");
  runFault_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && !pulseActive && !modDisabled && !wdogFail && !devFault
      |=> !ledDevFault)
    else $error("device amber on without cause");
  pulseEnd_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(pulseActive) |-> pulseDone)
    else $error("power-up blink not closed");
  pulseOnce_a : assert property (@(posedge mclk) disable iff (!rst_n)
    pulseDone |-> !pulseActive)
    else $error("power-up blink repeated");
  unconfCh_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && !chConfigured[7] |=> ledChAmber[7] == $past(blink))
    else $error("unconfigured channel not blinking");
  relayAmber_a : assert property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && !isAnalog && !lowPower && modConfig && chConfigured[0]
      |=> !ledChAmber[0])
    else $error("relay amber on without cause");

  reachRun_c : cover property (@(posedge mclk) disable iff (!rst_n) state == CSL_ST_RUN);
  pulse_c    : cover property (@(posedge mclk) disable iff (!rst_n) pulseDone);
  irq_c      : cover property (@(posedge mclk) disable iff (!rst_n) irq);
  wdog_c     : cover property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && wdogFail);
  lowAlarm_c : cover property (@(posedge mclk) disable iff (!rst_n)
    state == CSL_ST_RUN && isAnalog && (|chLowAlarm));
endmodule

// [design/csl_pkg.sv]
// Shared constants and types for the channel status LED sequencer.
package csl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned ADDR_SHOW_MS    = 2000;
  localparam int unsigned ADDR_SHOW_CYC   = (CLK_HZ / 1000) * ADDR_SHOW_MS;
  localparam int unsigned STEP_MS         = 100;
  localparam int unsigned STEP_CYC        = (CLK_HZ / 1000) * STEP_MS;
  localparam int unsigned BLINK_HALF_MS   = 250;
  localparam int unsigned BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned NUM_CH          = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_INTSTAT  = 4'h8;
  localparam logic [3:0] REG_INTMASK  = 4'hC;
  localparam int unsigned CTRL_VARIANT   = 0;
  localparam int unsigned CTRL_CONFIGURED = 1;
  localparam int unsigned CTRL_DISABLED  = 2;
  localparam int unsigned INT_SEQ_DONE   = 0;
  localparam int unsigned INT_WDOG       = 1;
  localparam int unsigned INT_FAULT      = 2;
  localparam logic [2:0] CTRL_RESET    = 3'h0;
  localparam logic [2:0] INTMASK_RESET = 3'h0;

  typedef enum logic [2:0] {
    CSL_ST_START, CSL_ST_RED_ON, CSL_ST_RED_OFF, CSL_ST_AMB_ON, CSL_ST_AMB_OFF,
    CSL_ST_ADDR, CSL_ST_RUN
  } csl_state_t;

endpackage

// [design/csl_tick_if.sv]
// Timing ticks shared between the sequencer and its tick generator.
`timescale 1ns/1ps
interface csl_tick_if;
  logic stepTick;
  logic blinkPhase;
  logic addrDone;
  logic addrStart;
  modport gen (output stepTick, output blinkPhase, output addrDone, input addrStart);
  modport use_ (input stepTick, input blinkPhase, input addrDone, output addrStart);
endinterface

// [design/csl_ticks.sv]
// Step, blink and address-hold timers.
`timescale 1ns/1ps
module csl_ticks
  import csl_pkg::*;
#(
  parameter int unsigned STEP_CYCLES  = STEP_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC,
  parameter int unsigned ADDR_CYCLES  = ADDR_SHOW_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  csl_tick_if.gen   tk
);
  logic [31:0] stepCnt;
  logic [31:0] blinkCnt;
  logic [31:0] addrCnt;
  logic        addrRun;
  logic        blinkPhase;

  wire stepWrap  = (stepCnt == STEP_CYCLES - 1);
  wire blinkWrap = (blinkCnt == BLINK_CYCLES - 1);
  wire addrWrap  = addrRun && (addrCnt == ADDR_CYCLES - 1);

  assign tk.stepTick   = stepWrap;
  assign tk.blinkPhase = blinkPhase;
  assign tk.addrDone   = addrWrap;

  // One blink generator serves every blinking LED.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stepCnt    <= 32'h0;
      blinkCnt   <= 32'h0;
      blinkPhase <= 1'b0;
    end else begin
      stepCnt    <= stepWrap ? 32'h0 : stepCnt + 32'h1;
      blinkCnt   <= blinkWrap ? 32'h0 : blinkCnt + 32'h1;
      blinkPhase <= blinkWrap ? ~blinkPhase : blinkPhase;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addrCnt <= 32'h0;
      addrRun <= 1'b0;
    end else if (tk.addrStart) begin
      addrCnt <= 32'h0;
      addrRun <= 1'b1;
    end else if (addrRun) begin
      addrCnt <= addrCnt + 32'h1;
      addrRun <= !addrWrap;
    end
  end

  stepPeriod_a : assert property (@(posedge mclk) disable iff (!rst_n)
    stepWrap |=> !stepWrap)
    else $error("step tick lasted more than one cycle");
endmodule

// [testbench/csl_panel_model.sv]
// Front-panel partner model: the network address DIP switch bank.
`timescale 1ns/1ps
module csl_panel_model
  import csl_pkg::*;
(
  input  wire logic [NUM_CH-1:0] addrSet,
  output logic      [NUM_CH-1:0] addrSwitch
);
  // Switches are plain levels that never float, so they follow the setting directly.
  assign addrSwitch = addrSet;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the channel status LED sequencer.
`timescale 1ns/1ps
module tb_top
  import csl_pkg::*;
;
  localparam int SC = 4;
  localparam int BC = 3;
  localparam int AC = 20;
  logic              mclk, rst_n, lowPower, wdogFail, devFault, regWr, regRd;
  logic              irq, ledPower, ledDevFault, rdPend, pd;
  logic [NUM_CH-1:0] addrSet, addrSwitch, chOutActive, chLowAlarm, chHighAlarm;
  logic [NUM_CH-1:0] chOutOfRange, chConfigured, ledChRed, ledChAmber;
  logic [3:0]        regAddr;
  logic [31:0]       regWdata, regRdata;
  logic [31:0]       rdq[$];
  logic [15:0]       ledq[$];
  logic [15:0]       prevLed;
  int                seed, bad_count, num_checks;

  csl_panel_model panel (.addrSet(addrSet), .addrSwitch(addrSwitch));

  csl_led_sequencer #(.STEP_CYCLES(SC), .BLINK_CYCLES(BC), .ADDR_CYCLES(AC)) dut (
    .mclk(mclk), .rst_n(rst_n), .addrSwitch(addrSwitch), .chOutActive(chOutActive),
    .chLowAlarm(chLowAlarm), .chHighAlarm(chHighAlarm), .chOutOfRange(chOutOfRange),
    .chConfigured(chConfigured), .lowPower(lowPower), .wdogFail(wdogFail),
    .devFault(devFault), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .irq(irq), .ledPower(ledPower),
    .ledDevFault(ledDevFault), .ledChRed(ledChRed), .ledChAmber(ledChAmber));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Checking and result monitor
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk) rdPend <= regRd;

  always @(negedge mclk) begin
    if (rdPend === 1'b1 && rdq.size() > 0)
      chk("regRdata", regRdata, rdq.pop_front());
    if ({ledChRed, ledChAmber} !== prevLed && ledq.size() > 0)
      chk("lamp pattern", {16'h0, ledChRed, ledChAmber}, {16'h0, ledq.pop_front()});
    prevLed = {ledChRed, ledChAmber};
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= ($random(seed) & 32'hFFFFFFF8) | d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    rdq.push_back(e);
    @(posedge mclk);
    regRd   <= 1'b0;
  endtask

  task automatic doReset;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("lamps in reset", 32'({ledPower, ledDevFault, ledChRed, ledChAmber}), 0);
    rst_n <= 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    chk("first lamps", 32'({ledPower, ledDevFault, ledChRed, ledChAmber}), 32'h30000);
  endtask

  task automatic devHold(input logic e);
    repeat (2) @(posedge mclk);
    repeat (10) begin
      @(negedge mclk);
      chk("device amber", 32'(ledDevFault), 32'(e));
    end
  endtask

  // Red and amber may each be steady (f) or blink in unison over the bits of b.
  task automatic blinkChk(input logic [7:0] rf, rb, af, ab, input int len);
    int         rc, ac;
    logic [7:0] pr, pa;
    rc = 0;
    ac = 0;
    repeat (2) @(negedge mclk);
    pr = ledChRed;
    pa = ledChAmber;
    repeat (len) begin
      @(negedge mclk);
      chk("red lamps", 32'(ledChRed === rf || ledChRed === (rf | rb)), 1);
      chk("amber lamps", 32'(ledChAmber === af || ledChAmber === (af | ab)), 1);
      chk("power lamp", 32'(ledPower), 1);
      rc += int'(ledChRed !== pr);
      ac += int'(ledChAmber !== pa);
      pr = ledChRed;
      pa = ledChAmber;
    end
    chk("red blinking", 32'(rc > 0), 32'(rb != 8'h00));
    chk("amber blinking", 32'(ac > 0), 32'(ab != 8'h00));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [8:0] m;
    logic [7:0] pat, rv, cv;
    int         n, r;
    seed = 32'hAB2482A3;
    {rst_n, regWr, regRd, lowPower, wdogFail, devFault, rdPend} = 7'h00;
    {chOutActive, chLowAlarm, chHighAlarm, chOutOfRange, chConfigured} = 40'h0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    prevLed = 16'h0;
    bad_count = 0;
    num_checks = 0;
    addrSet = 8'($random(seed)) | 8'h01;
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 8; k++) begin
        m = (9'h002 << k) - 9'h001;
        pat = p[0] ? ~m[7:0] : m[7:0];
        ledq.push_back(p < 2 ? {pat, 8'h00} : {8'h00, pat});
      end
    ledq.push_back({addrSet, 8'h00});
    doReset();
    n = 0;
    while (ledq.size() > 0 && n < 600) begin
      @(negedge mclk);
      #1;
      chk("fault lamp in test", 32'(ledDevFault), 1);
      n++;
    end
    if (n == 600) begin
      bad_count++;
      summarize();
    end
    n = 0;
    while (ledDevFault !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk("address hold", 32'(n), 32'(AC));
    fork
      blinkChk(8'h00, 8'h00, 8'h00, 8'hFF, 40);
      begin
        r = 0;
        pd = 1'b0;
        repeat (40) begin
          @(negedge mclk);
          r += int'(ledDevFault === 1'b1 && pd === 1'b0);
          pd = ledDevFault;
        end
        chk("device amber blinks", 32'(r), 1);
      end
    join
    rd(REG_CTRL, 32'(CTRL_RESET));
    rd(REG_INTMASK, 32'(INTMASK_RESET));
    rd(REG_INTSTAT, 32'h1);
    rd(4'h2, 32'h0);
    wr(REG_INTMASK, 32'h1);
    @(negedge mclk);
    chk("irq", 32'(irq), 1);
    wr(REG_INTSTAT, 32'h1);
    @(negedge mclk);
    chk("irq", 32'(irq), 0);
    rd(REG_INTSTAT, 32'h0);
    wr(REG_INTMASK, 32'h6);
    wdogFail <= 1'b1;
    devHold(1'b1);
    chk("irq", 32'(irq), 1);
    wdogFail <= 1'b0;
    devHold(1'b0);
    wr(REG_INTSTAT, 32'h6);
    rd(REG_INTSTAT, 32'h0);
    wr(REG_CTRL, 32'h4);
    devHold(1'b1);
    wr(REG_CTRL, 32'h0);
    devFault <= 1'b1;
    devHold(1'b1);
    devFault <= 1'b0;
    rd(REG_INTSTAT, 32'h4);
    wr(REG_INTSTAT, 32'h4);
    rv = 8'($random(seed));
    cv = 8'($random(seed)) & 8'h7F;
    chConfigured <= 8'hFF;
    chOutActive <= rv;
    wr(REG_CTRL, 32'h2);
    blinkChk(rv, 8'h00, 8'h00, 8'h00, 12);
    chConfigured <= cv;
    blinkChk(rv, 8'h00, 8'h00, ~cv, 12);
    lowPower <= 1'b1;
    blinkChk(rv, 8'h00, 8'h00, 8'hFF, 12);
    lowPower <= 1'b0;
    chConfigured <= 8'hFF;
    chOutActive <= 8'h00;
    chHighAlarm <= 8'h0F;
    chLowAlarm <= 8'hF0;
    chOutOfRange <= 8'h3D;
    wr(REG_CTRL, 32'h3);
    blinkChk(8'h0F, 8'hF0, 8'h3D, 8'h00, 12);
    doReset();
    summarize();
  end
endmodule
